// >>> vfcgp_top.sv
// control, power-down and pulse output of the synchronous converter
`timescale 1ns/10ps
// Behaviour
// - master clock comes from external clock input or crystal across both clock pins
// - master clock appears on clock output pin in crystal mode, outside standby; light load, buffer before reuse
// - power_down_n low enters standby; no valid pulse output
// - unsynchronised gate may give one count error; tolerated
// - pulse rate spans 0.05 to 0.45 of the master clock
// - each pulse starts on a clock edge, one full clock period wide
module vfcgp_top
  import vfcgp_pkg::*;
#(
  parameter int unsigned START_CYCLES = XTAL_START_CYC
)
(
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        power_down_n,
  input  wire logic                        crystal_select,
  input  wire logic [vfcgp_pkg::CODE_W-1:0] input_code,
  output logic                             pulse_out,
  output logic                             clock_out_en,
  output logic                             standby,
  output logic                             output_valid
);
  import vfcgp_pkg::*;

  typedef struct packed
  {
    logic                   wake_s1;
    logic                   wake_s2;
    logic                   xs_s1;
    logic                   xs_s2;
    logic [CODE_W-1:0]      code_s1;
    logic [CODE_W-1:0]      code_s2;
    logic [CODE_W-1:0]      code_hold;
    logic [1:0]             strap_cnt;
    logic                   strap_taken;
    logic                   crystal_mode;
    vfcgp_state_t           st;
    logic [START_CNT_W-1:0] start_cnt;
    logic [3:0]             settle_cnt;
    logic                   pulse;
    logic                   clk_en;
    logic                   standby;
    logic                   valid;
  } vfcgp_top_t;

  vfcgp_top_t s_q;
  vfcgp_top_t s_d;
  logic       rst_s1;
  logic       rst_n;
  logic       gen_pulse;
  logic       gen_en;
  logic       code_chg;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // pulses only while the modulator is powered and clocked
  assign gen_en = (s_q.st == VFCGP_SETTLE) || (s_q.st == VFCGP_RUN);

  vfcgp_rate_gen u_gen
  (
    .clock  (clock),
    .rst_n  (rst_n),
    .enable (gen_en),
    .code   (s_q.code_s2),
    .pulse  (gen_pulse)
  );

  always_comb
  begin
    s_d         = s_q;
    s_d.wake_s1 = power_down_n;
    s_d.wake_s2 = s_q.wake_s1;
    s_d.xs_s1   = crystal_select;
    s_d.xs_s2   = s_q.xs_s1;
    s_d.code_s1 = input_code;
    s_d.code_s2 = s_q.code_s1;
    s_d.code_hold = s_q.code_s2;
    code_chg    = s_q.code_s2 != s_q.code_hold;
    // strap is caught once, after the synchroniser has filled
    if (!s_q.strap_taken)
    begin
      s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      if (s_q.strap_cnt == STRAP_WAIT)
      begin
        s_d.strap_taken  = 1'b1;
        s_d.crystal_mode = s_q.xs_s2;
      end
    end
    case (s_q.st)
      VFCGP_OFF:
      begin
        if (s_q.wake_s2 && s_q.strap_taken)
        begin
          if (s_q.crystal_mode)
          begin
            // oscillator needs its start-up time before pulses mean anything
            s_d.st        = VFCGP_START;
            s_d.start_cnt = START_CNT_W'(START_CYCLES - 1);
          end
          else
          begin
            s_d.st         = VFCGP_SETTLE;
            s_d.settle_cnt = SETTLE_CYC;
          end
        end
      end
      VFCGP_START:
      begin
        s_d.start_cnt = s_q.start_cnt - 1'b1;
        if (s_q.start_cnt == '0)
        begin
          s_d.st         = VFCGP_SETTLE;
          s_d.settle_cnt = SETTLE_CYC;
        end
      end
      VFCGP_SETTLE:
      begin
        if (code_chg)
          s_d.settle_cnt = SETTLE_CYC;
        else if (s_q.settle_cnt == 4'h1)
          s_d.st = VFCGP_RUN;
        else
          s_d.settle_cnt = s_q.settle_cnt - 4'h1;
      end
      VFCGP_RUN:
      begin
        // an input step restarts settling
        if (code_chg)
        begin
          s_d.st         = VFCGP_SETTLE;
          s_d.settle_cnt = SETTLE_CYC;
        end
      end
      default:
        s_d.st = VFCGP_OFF;
    endcase
    if (!s_q.wake_s2)
      s_d.st = VFCGP_OFF;
    // pulses stay on clock edges; a free-running gate may see one more or less
    s_d.pulse   = gen_pulse && gen_en && s_q.wake_s2;
    s_d.standby = s_d.st == VFCGP_OFF;
    s_d.valid   = s_d.st == VFCGP_RUN;
    // drive the clock output only when a crystal makes the clock here
    s_d.clk_en  = s_q.crystal_mode && (s_d.st != VFCGP_OFF);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q         <= '0;
      s_q.st      <= VFCGP_OFF;
      s_q.standby <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign pulse_out    = s_q.pulse;
  assign clock_out_en = s_q.clk_en;
  assign standby      = s_q.standby;
  assign output_valid = s_q.valid;

  // checking helpers: cycles since the last pulse while running
  logic [4:0] gap_q;
  logic       gap_ok_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap_q    <= '0;
      gap_ok_q <= 1'b0;
    end
    else if (s_q.st != VFCGP_RUN)
    begin
      gap_q    <= '0;
      gap_ok_q <= 1'b0;
    end
    else if (pulse_out)
    begin
      gap_q    <= 5'h1;
      gap_ok_q <= 1'b1;
    end
    else if (gap_q != 5'h1F)
      gap_q <= gap_q + 5'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_standby_quiet: assert property (standby |-> !pulse_out)
    else $error("pulse seen in standby");
  a_sleep_enter: assert property ($fell(s_q.wake_s2) |-> ##2 (standby && !output_valid))
    else $error("power down did not reach standby");
  a_pulse_width: assert property (pulse_out |=> !pulse_out)
    else $error("pulse wider than one clock");
  a_gap_floor: assert property ((gap_ok_q && gap_q < 5'h1F) |-> gap_q <= GAP_MAX)
    else $error("pulse rate below low end");
  a_gap_ceiling: assert property ((gap_ok_q && pulse_out) |-> gap_q >= GAP_MIN)
    else $error("pulse rate above high end");
  a_clock_drive: assert property ((s_q.crystal_mode && !standby) |-> clock_out_en)
    else $error("clock output not driven with crystal");
  a_start_quiet: assert property ((s_q.st == VFCGP_START) |=> !pulse_out)
    else $error("pulse during oscillator start");
  a_valid_settle: assert property ($rose(output_valid) |-> $past(s_q.st, 2) == VFCGP_SETTLE)
    else $error("valid raised without settling");

  c_run_pulse: cover property (output_valid && pulse_out);
  c_standby: cover property ($rose(standby));
  c_settle_done: cover property ($rose(output_valid));
endmodule

// >>> vfcgp_pkg.sv
// shared constants and types for the gated pulse converter logic
package vfcgp_pkg;
  localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
  localparam int unsigned XTAL_START_US = 5000;
  localparam int unsigned XTAL_START_CYC = XTAL_START_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned START_CNT_W   = 20;
  localparam logic [3:0]  SETTLE_CYC    = 4'hA;
  localparam logic [3:0]  SETTLE_CYC_MC = 4'h2;
  localparam int unsigned CODE_W        = 12;
  localparam int unsigned ACC_W         = 16;
  // 0.05 and 0.40 of the accumulator range, giving 0.05 .. 0.45 of the clock
  localparam logic [15:0] STEP_MIN      = 16'h0CCD;
  localparam logic [15:0] STEP_SPAN     = 16'h6666;
  localparam logic [1:0]  STRAP_WAIT    = 2'h3;
  localparam logic [4:0]  GAP_MAX       = 5'h14;
  localparam logic [4:0]  GAP_MIN       = 5'h02;

  typedef enum logic [1:0]
  {
    VFCGP_OFF    = 2'b00,
    VFCGP_START  = 2'b01,
    VFCGP_SETTLE = 2'b11,
    VFCGP_RUN    = 2'b10
  } vfcgp_state_t;
endpackage

// >>> vfcgp_rate_gen.sv
// phase accumulator that turns a code into a clock-synchronous pulse rate
`timescale 1ns/10ps
module vfcgp_rate_gen
  import vfcgp_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         enable,
  input  wire logic [vfcgp_pkg::CODE_W-1:0] code,
  output logic                              pulse
);
  import vfcgp_pkg::*;

  typedef struct packed
  {
    logic [ACC_W-1:0] acc;
    logic             pulse;
  } vfcgp_gen_t;

  vfcgp_gen_t       s_q;
  vfcgp_gen_t       s_d;
  logic [27:0]      prod;
  logic [ACC_W-1:0] step;
  logic [ACC_W:0]   sum;

  always_comb
  begin
    prod = 28'(code) * 28'(STEP_SPAN);
    step = STEP_MIN + prod[27:12];
    sum  = {1'b0, s_q.acc} + {1'b0, step};
    s_d  = s_q;
    if (enable)
    begin
      s_d.acc   = sum[ACC_W-1:0];
      // carry out starts one pulse, always one clock wide; step below half range
      s_d.pulse = sum[ACC_W];
    end
    else
    begin
      s_d.acc   = '0;
      s_d.pulse = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pulse = s_q.pulse;
endmodule

// >>> vfcgp_gate_counter.sv
// gated pulse counter model on the far side of the converter
`timescale 1ns/10ps
module vfcgp_gate_counter
#(
  parameter int GATE_W = 9
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        pulse,
  output logic [GATE_W:0]  result,
  output logic             result_new
);
  logic [GATE_W:0] div_q;
  logic [GATE_W:0] cnt_q;
  logic            pulse_q;
  logic            rise;
  assign rise = pulse & ~pulse_q;
  // gate is the top divider bit, so clock drift cancels out
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q      <= '0;
      cnt_q      <= '0;
      pulse_q    <= 1'b0;
      result     <= '0;
      result_new <= 1'b0;
    end
    else
    begin
      div_q      <= div_q + 1'b1;
      pulse_q    <= pulse;
      result_new <= 1'b0;
      if (div_q[GATE_W] && rise)
        cnt_q <= cnt_q + 1'b1;
      if (&div_q)
      begin
        result     <= cnt_q + {{GATE_W{1'b0}}, rise};
        cnt_q      <= '0;
        result_new <= 1'b1;
      end
    end
  end
endmodule

// >>> vfcgp_top_bench.sv
// self-checking bench for the synchronous converter control
`timescale 1ns/10ps
module vfcgp_top_bench;
  import vfcgp_pkg::*;
  localparam int START_SIM = 20;
  localparam int GATE_W    = 9;
  logic              clock = 1'b0;
  logic              arst_n;
  logic              power_down_n;
  logic              crystal_select;
  logic [CODE_W-1:0] input_code;
  logic              pulse_out;
  logic              clock_out_en;
  logic              standby;
  logic              output_valid;
  logic [GATE_W:0]   result;
  logic              result_new;
  logic              pulse_prev = 1'b0;
  int                fails;
  int                num_checks;

  vfcgp_top #(.START_CYCLES(START_SIM)) vfcgp_top_i
  (
    .clock(clock), .arst_n(arst_n), .power_down_n(power_down_n),
    .crystal_select(crystal_select), .input_code(input_code),
    .pulse_out(pulse_out), .clock_out_en(clock_out_en),
    .standby(standby), .output_valid(output_valid)
  );
  vfcgp_gate_counter #(.GATE_W(GATE_W)) vfcgp_gate_counter_i
  (
    .clock(clock), .rst_n(arst_n), .pulse(pulse_out),
    .result(result), .result_new(result_new)
  );

  always #5 clock = ~clock;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
    num_checks++;
    if (seen !== expd)
    begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", what, expd, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wait_valid(output int n);
    n = 0;
    while (output_valid !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    // a settle that never ends must not slip past the callers' count checks
    check("valid_wait", output_valid, 1'b1);
  endtask

  // pulses are looked at mid-cycle, away from the launching edge
  always @(negedge clock)
  begin
    if (pulse_out === 1'b1)
    begin
      check("pulse_width", pulse_prev, 1'b0);
      check("pulse_standby", standby, 1'b0);
    end
    pulse_prev = pulse_out;
  end

  task automatic t_external;
    int n;
    wait_valid(n);
    check("settle_ext", n >= SETTLE_CYC, 1'b1);
    check("clock_drive_ext", clock_out_en, 1'b0);
    $display("test external clock done");
  endtask

  task automatic t_rate(input logic [CODE_W-1:0] code);
    int  n;
    real ideal;
    input_code = code;
    tick(4);
    check("resettle", output_valid, 1'b0);
    wait_valid(n);
    repeat (2)
    begin
      n = 0;
      do
      begin
        tick(1);
        n++;
      end while (result_new !== 1'b1 && n < 2200);
    end
    check("gate_wait", n < 2200, 1'b1);
    ideal = (2.0 ** GATE_W) * (0.05 + 0.4 * code / 4096.0);
    check("rate_count", result - ideal <= 1.0 && ideal - result <= 1.0, 1'b1);
    $display("test rate %0h done, count %0d", code, result);
  endtask

  task automatic t_powerdown;
    int n;
    power_down_n = 1'b0;
    tick(3);
    check("standby_on", {standby, output_valid}, 2'h2);
    tick(30);
    power_down_n = 1'b1;
    wait_valid(n);
    check("settle_wake", n >= SETTLE_CYC, 1'b1);
    $display("test power-down done");
  endtask

  task automatic t_crystal;
    int n;
    int p;
    arst_n = 1'b0;
    crystal_select = 1'b1;
    tick(2);
    arst_n = 1'b1;
    n = 0;
    while (clock_out_en !== 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    check("clock_drive_xtal", clock_out_en, 1'b1);
    p = 0;
    repeat (START_SIM)
    begin
      p += (pulse_out === 1'b1);
      tick(1);
    end
    check("start_quiet", p, 0);
    wait_valid(n);
    check("settle_xtal", n >= SETTLE_CYC, 1'b1);
    power_down_n = 1'b0;
    tick(3);
    check("clock_drive_stby", {clock_out_en, standby}, 2'h1);
    $display("test crystal done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // the run needs roughly 6300 cycles
  initial
  begin
    #300us;
    fails++;
    conclude();
  end

  initial
  begin
    arst_n = 1'b0;
    power_down_n = 1'b1;
    crystal_select = 1'b0;
    input_code = '0;
    fails = 0;
    num_checks = 0;
    tick(12);
    check("reset_out", {pulse_out, clock_out_en, standby, output_valid}, 4'h2);
    arst_n = 1'b1;
    t_external();
    t_rate(12'hFFF);
    t_rate(12'h000);
    t_rate(12'h800);
    t_powerdown();
    t_crystal();
    conclude();
  end
endmodule
